// >>> hw/dctr_core.sv
// per-channel trim registers, command decode and readback of the dac
// Functional notes
// (RULE_01) config read is command byte F0
// (RULE_02) config answer echoes F0, then flag bits
// (RULE_03) adjusted code is code times gain, plus offset
// (RULE_04) offset trim signed, plus minus eighth scale
// (RULE_05) offset step one lsb, 8000 hex most negative
// (RULE_06) offset write nibble 2, 14 bits msb first
// (RULE_07) new offset waits for next code write
// (RULE_08) nibble 8 reads adjusted code after echo
// (RULE_09) twelve bit variant pads readback with zeros
// (RULE_10) gain trim signed, half to one and half
// (RULE_11) host computes gain code from percentage
// (RULE_12) gain write nibble 3, msb aligned trim
// (RULE_13) gain zero is unity, 8000 hex is half
// (RULE_14) new gain waits for next code write
// (RULE_15) 24 bit frame accepted without check byte
// (RULE_16) read data appears in the following frame
// (RULE_17) low command nibble selects one of sixteen
// (RULE_18) adjusted code saturates instead of wrapping
module dctr_core #(
    parameter int unsigned RESOLUTION = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_sck,
    input wire logic link_cs_n,
    input wire logic link_sdi,
    output logic link_sdo,
    input wire logic thermal_shutdown_disable,
    input wire logic external_reference_select,
    input wire logic crc_enable,
    output dctr_pkg::dctr_update_s dac_update
);
    localparam int unsigned SHIFT = dctr_pkg::FULL_W - RESOLUTION;
    localparam logic [15:0] GAIN_MASK = 16'(16'hFFFF << SHIFT);
    localparam logic [15:0] CODE_MAX = 16'(16'hFFFF >> SHIFT);

    typedef struct packed {
        logic [2:0] cs_sync;
        logic reset_flag;
        logic [31:0] resp;
        logic [15:0][15:0] code;
        logic [15:0][15:0] gain;
        logic [15:0][13:0] offset;
        logic [15:0][15:0] adj;
        dctr_pkg::dctr_update_s update;
    } dctr_core_s;

    dctr_core_s st;
    dctr_core_s next_st;
    dctr_pkg::dctr_link_s frame;

    logic frame_end;
    logic accept;
    logic [23:0] word;
    logic [7:0] cmd;
    logic [3:0] ch;
    logic [15:0] data;
    logic [15:0] code_in;
    logic [15:0] arith_out;
    logic [15:0] cfg_bits;

    dctr_spi_link u_link (
        .link_sck(link_sck),
        .link_cs_n(link_cs_n),
        .resetn(resetn),
        .link_sdi(link_sdi),
        .resp_word(st.resp),
        .frame(frame),
        .link_sdo(link_sdo)
    );

    dctr_trim_arith #(
        .RESOLUTION(RESOLUTION)
    ) u_arith (
        .code_in(code_in),
        .gain(st.gain[ch]),
        .offset(st.offset[ch]),
        .code_out(arith_out)
    );

    always_comb begin
        // frame end is the rising edge of the synchronised select
        frame_end = st.cs_sync[1] & ~st.cs_sync[2];
        // both frame lengths are taken [RULE_15]
        accept = frame_end && ((frame.bits == dctr_pkg::FRAME_SHORT) || (frame.bits == dctr_pkg::FRAME_LONG));
        word = (frame.bits == dctr_pkg::FRAME_LONG) ? frame.shift[31:8] : frame.shift[23:0];
        cmd = word[23:16];
        ch = cmd[3:0]; // [RULE_17]
        data = word[15:0];
        code_in = 16'(data >> SHIFT);
        cfg_bits = 16'h0000;
        cfg_bits[dctr_pkg::CFG_RST_BIT] = st.reset_flag;
        cfg_bits[dctr_pkg::CFG_TSD_BIT] = thermal_shutdown_disable;
        cfg_bits[dctr_pkg::CFG_EXT_BIT] = external_reference_select;
        cfg_bits[dctr_pkg::CFG_CRC_BIT] = crc_enable;
    end

    always_comb begin
        next_st = st;
        next_st.cs_sync = {st.cs_sync[1:0], link_cs_n};
        next_st.update.valid = 1'b0;
        if (frame_end) begin
            // an answer lives for one frame only [RULE_16]
            next_st.resp = dctr_pkg::RESP_RESET;
        end
        if (accept) begin
            if (cmd == dctr_pkg::CMD_READ_CFG) begin
                // echo and flags, trailing bits zero [RULE_01] [RULE_02]
                next_st.resp = {cmd, cfg_bits, dctr_pkg::TRAIL_BYTE};
                next_st.reset_flag = 1'b0;
            end else begin
                unique case (cmd[7:4])
                    dctr_pkg::OP_WRITE_CODE: begin
                        // only a code write refreshes the adjusted value [RULE_07] [RULE_14]
                        next_st.code[ch] = code_in;
                        next_st.adj[ch] = arith_out; // [RULE_03]
                        next_st.update.valid = 1'b1;
                        next_st.update.channel = ch;
                        next_st.update.code = arith_out;
                    end
                    dctr_pkg::OP_WRITE_OFFSET: begin
                        next_st.offset[ch] = data[15:2]; // [RULE_06]
                    end
                    dctr_pkg::OP_WRITE_GAIN: begin
                        next_st.gain[ch] = data & GAIN_MASK; // [RULE_12]
                    end
                    dctr_pkg::OP_READ_ADJ: begin
                        // msb aligned, zero padded [RULE_08] [RULE_09]
                        next_st.resp = {cmd, 16'(st.adj[ch] << SHIFT), dctr_pkg::TRAIL_BYTE};
                    end
                    default: begin
                        next_st.resp = dctr_pkg::RESP_RESET;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            next_st_reset: begin
                st.cs_sync <= 3'h7;
                st.reset_flag <= 1'b1;
                st.resp <= dctr_pkg::RESP_RESET;
                st.code <= {dctr_pkg::NUM_CH{dctr_pkg::CODE_RESET}};
                st.gain <= {dctr_pkg::NUM_CH{dctr_pkg::GAIN_RESET}};
                st.offset <= {dctr_pkg::NUM_CH{dctr_pkg::OFFSET_RESET}};
                st.adj <= {dctr_pkg::NUM_CH{dctr_pkg::CODE_RESET}};
                st.update <= '0;
            end
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        dac_update = st.update;
    end

    AST_CFG_ECHO: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_01]
        (accept && cmd == dctr_pkg::CMD_READ_CFG) |=> (st.resp[31:24] == 8'hF0) && (st.resp[7:0] == 8'h00))
        else $error("config read not echoed");

    AST_CFG_FLAGS: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
        (accept && cmd == dctr_pkg::CMD_READ_CFG) |=> (st.resp[22:19] == 4'h0) && !st.reset_flag
            && (st.resp[10] == $past(thermal_shutdown_disable)) && (st.resp[8] == $past(crc_enable)))
        else $error("config flags misplaced");

    AST_HOLD_TRIM: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07] [RULE_14]
        (accept && (cmd[7:4] == dctr_pkg::OP_WRITE_OFFSET || cmd[7:4] == dctr_pkg::OP_WRITE_GAIN))
            |=> !st.update.valid && $stable(st.adj))
        else $error("trim write changed output");

    AST_READBACK: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_08] [RULE_09]
        (accept && cmd[7:4] == dctr_pkg::OP_READ_ADJ)
            |=> st.resp == {$past(cmd), 16'($past(st.adj[ch]) << SHIFT), 8'h00})
        else $error("readback word wrong");

    AST_FRAME_LEN: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_15]
        st.update.valid |-> $past(frame.bits) == 6'h18 || $past(frame.bits) == 6'h20)
        else $error("update from bad frame length");

    AST_RESP_STABLE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_16]
        !$past(frame_end) |-> $stable(st.resp))
        else $error("answer changed inside a frame");

    AST_CHANNEL: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_17]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE) |=> st.update.valid && st.update.channel == $past(ch))
        else $error("wrong channel updated");

    AST_UNITY: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_03] [RULE_13]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'h0000 && st.offset[ch] == 14'h0000)
            |=> st.update.code == $past(code_in))
        else $error("unity trim altered code");

    AST_OFFSET_STEP: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_05]
        (RESOLUTION == 16 && accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'h0000
            && st.offset[ch] == 14'h3FFF && data != 16'h0000) |=> st.update.code == $past(data) - 16'h0001)
        else $error("minus one offset step wrong");

    AST_SATURATE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_18]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && data == 16'hFFFF && !st.gain[ch][15]
            && !st.offset[ch][13]) |=> st.update.code == CODE_MAX)
        else $error("overflow wrapped");

    AST_CFG_EXT: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
        (accept && cmd == dctr_pkg::CMD_READ_CFG)
            |=> (st.resp[9] == $past(external_reference_select)) && (st.resp[23] == $past(st.reset_flag)))
        else $error("config reference or reset flag wrong");

    AST_CFG_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
        (accept && cmd == dctr_pkg::CMD_READ_CFG)
            |=> (st.resp[22:11] == 12'h000))
        else $error("config reserved bits not zero");

    AST_NONREAD_QUIET: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_01] [RULE_16]
        (accept && cmd != dctr_pkg::CMD_READ_CFG && cmd[7:4] != dctr_pkg::OP_READ_ADJ)
            |=> st.resp == dctr_pkg::RESP_RESET)
        else $error("non read command left an answer");

    AST_OFFSET_STORE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_06] [RULE_17]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_OFFSET)
            |=> st.offset[$past(ch)] == $past(data[15:2]))
        else $error("offset trim not stored");

    AST_GAIN_STORE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_12] [RULE_17]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_GAIN)
            |=> st.gain[$past(ch)] == ($past(data) & GAIN_MASK))
        else $error("gain trim not stored");

    AST_STORE_CODE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07] [RULE_14]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE)
            |=> (st.adj[$past(ch)] == st.update.code) && (st.code[$past(ch)] == $past(code_in)))
        else $error("code write not stored");

    AST_UPDATE_CAUSE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07] [RULE_14]
        st.update.valid
            |-> $past(accept) && ($past(cmd[7:4]) == dctr_pkg::OP_WRITE_CODE))
        else $error("update without code write");

    AST_REFUSED: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_15]
        (frame_end && !accept)
            |=> !st.update.valid && (st.resp == dctr_pkg::RESP_RESET))
        else $error("bad length frame acted on");

    AST_PULSE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07]
        st.update.valid
            |=> !st.update.valid)
        else $error("update pulse too long");

    AST_RANGE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_09] [RULE_18]
        st.update.valid
            |-> (st.update.code <= CODE_MAX))
        else $error("adjusted code out of range");

    AST_HALF_GAIN: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_10] [RULE_13]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'h8000 && st.offset[ch] == 14'h0000)
            |=> st.update.code == ($past(code_in) >> 1))
        else $error("minimum gain not one half");

    AST_OFFSET_PLUS: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_05]
        (RESOLUTION == 16 && accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'h0000
            && st.offset[ch] == 14'h0001 && data != 16'hFFFF) |=> st.update.code == $past(data) + 16'h0001)
        else $error("plus one offset step wrong");

    AST_OFFSET_FLOOR: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_04] [RULE_18]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'h0000 && st.offset[ch] == 14'h2000
            && 16'(code_in << SHIFT) < 16'h2000) |=> st.update.code == 16'h0000)
        else $error("most negative offset did not clamp");

    AST_GAIN_NEG_ONE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_13]
        (RESOLUTION == 16 && accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE && st.gain[ch] == 16'hFFFF
            && st.offset[ch] == 14'h0000 && data != 16'h0000) |=> st.update.code == $past(data) - 16'h0001)
        else $error("minus one gain step wrong");

    AST_READ_PAD: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_09]
        (accept && cmd[7:4] == dctr_pkg::OP_READ_ADJ)
            |=> (st.resp[23:8] & ~GAIN_MASK) == 16'h0000)
        else $error("readback padding not zero");

    AST_TRIM_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07] [RULE_14]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE)
            |=> $stable(st.gain) && $stable(st.offset))
        else $error("code write changed a trim");

    AST_READ_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_08]
        (accept && (cmd[7:4] == dctr_pkg::OP_READ_ADJ || cmd == dctr_pkg::CMD_READ_CFG))
            |=> $stable(st.adj) && !st.update.valid)
        else $error("read changed the output");

    AST_RESET_FLAG: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
        !$past(st.reset_flag)
            |-> !st.reset_flag)
        else $error("reset flag set outside reset");

    AST_CHANNEL_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_17]
        (accept && cmd[7:4] == dctr_pkg::OP_WRITE_CODE)
            |=> st.adj[$past(ch) ^ 4'h1] == $past(st.adj[ch ^ 4'h1]))
        else $error("neighbour channel changed");
endmodule // dctr_core

// >>> hw/dctr_pkg.sv
// constants and carrier types of the dac code trim and readback block
package dctr_pkg;

    localparam int unsigned NUM_CH = 16;
    localparam int unsigned CH_W = 4;
    localparam int unsigned FULL_W = 16;
    localparam int unsigned OFFSET_W = 14;

    // command nibbles and the configuration read byte
    localparam logic [3:0] OP_WRITE_CODE = 4'h0;
    localparam logic [3:0] OP_WRITE_OFFSET = 4'h2;
    localparam logic [3:0] OP_WRITE_GAIN = 4'h3;
    localparam logic [3:0] OP_READ_ADJ = 4'h8;
    localparam logic [7:0] CMD_READ_CFG = 8'hF0;

    // frame lengths in bits, without and with the check byte
    localparam logic [5:0] FRAME_SHORT = 6'h18;
    localparam logic [5:0] FRAME_LONG = 6'h20;
    localparam logic [5:0] FRAME_MAX = 6'h3F;

    // configuration readback field positions within the 16 data bits
    localparam int unsigned CFG_RST_BIT = 15;
    localparam int unsigned CFG_TSD_BIT = 2;
    localparam int unsigned CFG_EXT_BIT = 1;
    localparam int unsigned CFG_CRC_BIT = 0;

    // values after reset and the trailing answer byte
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [13:0] OFFSET_RESET = 14'h0000;
    localparam logic [31:0] RESP_RESET = 32'h0000_0000;
    localparam logic [7:0] TRAIL_BYTE = 8'h00;

    // link domain state: bit count of the frame and the received bits
    typedef struct packed {
        logic [5:0] bits;
        logic [31:0] shift;
    } dctr_link_s;

    // one adjusted code handed to the converter core
    typedef struct packed {
        logic valid;
        logic [3:0] channel;
        logic [15:0] code;
    } dctr_update_s;

    // read commands make the next frame start with a one on serial out
    function automatic logic is_read(input logic [7:0] cmd);
        return (cmd == CMD_READ_CFG) || (cmd[7:4] == OP_READ_ADJ);
    endfunction

endpackage

// >>> hw/dctr_spi_link.sv
// serial link front end clocked by the host serial clock
module dctr_spi_link (
    input wire logic link_sck,
    input wire logic link_cs_n,
    input wire logic resetn,
    input wire logic link_sdi,
    input wire logic [31:0] resp_word,
    output dctr_pkg::dctr_link_s frame,
    output logic link_sdo
);
    logic armed;
    dctr_pkg::dctr_link_s next_frame;

    // armed while select is high, so the first edge of a frame restarts the count
    always_ff @(posedge link_sck or posedge link_cs_n or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b1;
        end else if (link_cs_n) begin
            armed <= 1'b1;
        end else begin
            armed <= 1'b0;
        end
    end

    always_comb begin
        next_frame = frame;
        if (armed) begin
            next_frame.bits = 6'h01;
            next_frame.shift = {31'h0000_0000, link_sdi};
        end else begin
            if (frame.bits != dctr_pkg::FRAME_MAX) begin
                next_frame.bits = frame.bits + 6'h01;
            end
            next_frame.shift = {frame.shift[30:0], link_sdi};
        end
    end

    always_ff @(posedge link_sck or negedge resetn) begin
        if (!resetn) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // out bit k goes on the falling edge after k rising edges
    always_ff @(negedge link_sck or negedge resetn) begin
        if (!resetn) begin
            link_sdo <= 1'b0;
        end else if (frame.bits == dctr_pkg::FRAME_SHORT) begin
            // first bit of the next frame's answer [RULE_16]
            link_sdo <= dctr_pkg::is_read(frame.shift[23:16]);
        end else if (frame.bits == dctr_pkg::FRAME_LONG) begin
            link_sdo <= dctr_pkg::is_read(frame.shift[31:24]);
        end else if (frame.bits < dctr_pkg::FRAME_LONG) begin
            link_sdo <= resp_word[5'(6'd31 - frame.bits)];
        end else begin
            link_sdo <= 1'b0;
        end
    end
endmodule // dctr_spi_link

// >>> hw/dctr_trim_arith.sv
// gain then offset arithmetic with saturation for one channel
module dctr_trim_arith #(
    parameter int unsigned RESOLUTION = 16
) (
    input wire logic [15:0] code_in,
    input wire logic [15:0] gain,
    input wire logic [13:0] offset,
    output logic [15:0] code_out
);
    localparam int unsigned SHIFT = dctr_pkg::FULL_W - RESOLUTION;

    logic signed [17:0] code_full;
    logic signed [34:0] product;
    logic signed [19:0] sum;
    logic [15:0] clamped;

    always_comb begin
        code_full = $signed(18'(16'(code_in << SHIFT)));
        // gain is a signed fraction of full scale, applied before offset [RULE_03] [RULE_10] [RULE_13]
        product = 35'(code_full) * 35'($signed(gain));
        // offset is signed, one full-scale lsb per step [RULE_04] [RULE_05]
        sum = 20'(code_full) + 20'(product >>> 16) + 20'($signed(offset));
        // clamp instead of wrapping [RULE_18]
        if (sum < 20'sd0) begin
            clamped = 16'h0000;
        end else if (sum > 20'sd65535) begin
            clamped = 16'hFFFF;
        end else begin
            clamped = sum[15:0];
        end
        code_out = 16'(clamped >> SHIFT);
    end
endmodule // dctr_trim_arith

// >>> sim/dctr_host_model.sv
// host controller model driving the serial command link of the trim block
module dctr_host_model (
    output logic link_sck,
    output logic link_cs_n,
    output logic link_sdi,
    input wire logic link_sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        link_sck = 1'b0;
        link_cs_n = 1'b1;
        link_sdi = 1'b0;
    end

    // one frame, msb first, nbits bits long; the serial clock stands low outside frames
    task automatic frame(input logic [31:0] word, input int nbits, output logic [31:0] rx);
        rx = 32'h0000_0000;
        link_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            link_sdi = word[31 - i];
            #16;
            link_sck = 1'b1;
            rx[31 - i] = link_sdo;
            #16;
            link_sck = 1'b0;
        end
        #8;
        link_cs_n = 1'b1;
        // released data line shows the inverse of its last bit
        link_sdi = ~link_sdi;
        #100;
    endtask
endmodule // dctr_host_model

// >>> sim/dctr_trim_bench.sv
// self-checking bench of the dac code trim and readback block
module dctr_core_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic resetn;
    logic link_sck;
    logic link_cs_n;
    logic link_sdi;
    logic link_sdo;
    logic thermal_shutdown_disable;
    logic external_reference_select;
    logic crc_enable;
    dctr_pkg::dctr_update_s dac_update;
    logic [31:0] rx;
    logic [15:0] gain_t [16];
    logic [13:0] off_t [16];
    logic [15:0] adj_t [16];
    logic [3:0] last_ch;
    logic [15:0] last_code;
    int upd_cnt = 0;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    dctr_core #(.RESOLUTION(16)) dctr_core_i (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .link_sck(link_sck),
        .link_cs_n(link_cs_n),
        .link_sdi(link_sdi),
        .link_sdo(link_sdo),
        .thermal_shutdown_disable(thermal_shutdown_disable),
        .external_reference_select(external_reference_select),
        .crc_enable(crc_enable),
        .dac_update(dac_update)
    );

    dctr_host_model dctr_host_model_i (
        .link_sck(link_sck),
        .link_cs_n(link_cs_n),
        .link_sdi(link_sdi),
        .link_sdo(link_sdo)
    );

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (dac_update.valid === 1'b1) begin
            upd_cnt++;
            last_ch = dac_update.channel;
            last_code = dac_update.code;
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask

    // expected code: gain first, then offset, clamped to the code range
    function automatic logic [15:0] adj(input logic [15:0] c, input logic [15:0] g, input logic [13:0] o);
        longint p;
        longint s;
        p = longint'(c) * longint'($signed(g));
        s = longint'(c) + (p >>> 16) + longint'($signed(o));
        if (s < 0) s = 0;
        else if (s > 65535) s = 65535;
        return s[15:0];
    endfunction

    // host side gain code from a percentage
    function automatic logic [15:0] computed_gain_code(input real pct);
        return 16'(int'(pct * 655.36));
    endfunction

    task automatic xf(input logic [7:0] cmd, input logic [15:0] d, input int n);
        @(posedge sys_clk);
        #1;
        dctr_host_model_i.frame({cmd, d, 8'h5A}, n, rx);
    endtask

    task automatic wr_code(input logic [3:0] ch, input logic [15:0] c, input int n);
        int n0;
        n0 = upd_cnt;
        xf({dctr_pkg::OP_WRITE_CODE, ch}, c, n);
        for (int k = 0; k < 50 && upd_cnt == n0; k++) @(posedge sys_clk);
        adj_t[ch] = adj(c, gain_t[ch], off_t[ch]);
        chk(32'(upd_cnt - n0), 32'h1);
        chk({28'h0, last_ch}, {28'h0, ch});
        chk({16'h0, last_code}, {16'h0, adj_t[ch]});
    endtask

    task automatic wr_off(input logic [3:0] ch, input logic [13:0] o);
        off_t[ch] = o;
        xf({dctr_pkg::OP_WRITE_OFFSET, ch}, {o, 2'b00}, 24);
    endtask

    task automatic wr_gain(input logic [3:0] ch, input logic [15:0] g);
        gain_t[ch] = g;
        xf({dctr_pkg::OP_WRITE_GAIN, ch}, g, 24);
    endtask

    task automatic rd_adj(input logic [3:0] ch);
        xf({dctr_pkg::OP_READ_ADJ, ch}, 16'h0000, 24);
        xf(8'h10, 16'h0000, 24);
        chk(rx, {dctr_pkg::OP_READ_ADJ, ch, adj_t[ch], 8'h00});
    endtask

    initial begin
        int n0;
        sys_clk = 1'b0;
        resetn = 1'b0;
        thermal_shutdown_disable = 1'b1;
        external_reference_select = 1'b0;
        crc_enable = 1'b1;
        for (int i = 0; i < 16; i++) begin
            gain_t[i] = 16'h0000;
            off_t[i] = 14'h0000;
            adj_t[i] = 16'h0000;
        end
        repeat (16) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge sys_clk);

        xf(dctr_pkg::CMD_READ_CFG, 16'hFFFF, 24);
        @(posedge sys_clk);
        #1;
        external_reference_select = 1'b1;
        xf(dctr_pkg::CMD_READ_CFG, 16'h0000, 24);
        chk(rx, {8'hF0, 16'h8005, 8'h00});
        xf(8'h10, 16'h0000, 24);
        chk(rx, {8'hF0, 16'h0007, 8'h00});
        $display("test config read done");

        for (int ch = 0; ch < 16; ch++) wr_code(4'(ch), {4'(ch), 12'h234}, 24);
        wr_code(4'h3, 16'h1234, 32);
        $display("test channel select done");

        wr_off(4'h5, 14'h0001);
        rd_adj(4'h5);
        wr_code(4'h5, 16'h1000, 24);
        wr_off(4'h5, 14'h2000);
        wr_code(4'h5, 16'h1000, 24);
        wr_off(4'h5, 14'h3FFF);
        wr_code(4'h5, 16'h8000, 24);
        wr_off(4'h5, 14'h1FFF);
        wr_code(4'h5, 16'hFFFF, 24);
        rd_adj(4'h5);
        $display("test offset trim done");

        wr_gain(4'h7, computed_gain_code(-50.0));
        rd_adj(4'h7);
        wr_code(4'h7, 16'h8000, 24);
        wr_gain(4'h7, 16'hFFFF);
        wr_code(4'h7, 16'h8000, 24);
        wr_gain(4'h7, computed_gain_code(49.9));
        wr_code(4'h7, 16'hFFFF, 24);
        rd_adj(4'h7);
        $display("test gain trim done");

        n0 = upd_cnt;
        xf(8'h01, 16'hAAAA, 20);
        xf(8'h01, 16'hAAAA, 25);
        chk(32'(upd_cnt), 32'(n0));
        rd_adj(4'h7);
        $display("test refused frames done");
        results();
    end
endmodule // dctr_core_bench
